/* File: core/prescale_if.sv */
// Signals between the timer control and its prescaler.
`timescale 1ns/1ps
interface prescale_if;
  logic run;
  logic load;
  logic [7:0] value;
  logic tick;
  modport ctrl (output run, output load, output value, input tick);
  modport presc (input run, input load, input value, output tick);
endinterface : prescale_if

/* File: core/standard_down_timer.sv */
// Standard 16-bit down timer with register file access and interrupt routing.
`timescale 1ns/1ps
module standard_down_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic ext_irq_pin,
  output logic irq_channel,
  output logic end_of_count
);
  import std_timer_pkg::*;

  prescale_if pif ();

  logic [7:0] constant_high;
  logic [7:0] constant_low;
  logic [7:0] prescaler_value;
  logic [7:0] timer_control;
  logic [15:0] live_count;
  logic constant_pending;
  logic page_hit;
  logic wr_high;
  logic wr_low;
  logic wr_presc;
  logic wr_ctrl;
  logic eoc;
  logic run_rise;
  logic run_prev;

  // Register selection within page 11.
  always_comb begin
    page_hit = (reg_page == REG_PAGE);
    wr_high = reg_wr && page_hit && (reg_addr == ADDR_COUNTER_HIGH);
    wr_low = reg_wr && page_hit && (reg_addr == ADDR_COUNTER_LOW);
    wr_presc = reg_wr && page_hit && (reg_addr == ADDR_PRESCALER);
    wr_ctrl = reg_wr && page_hit && (reg_addr == ADDR_CONTROL);
    eoc = pif.tick && timer_control[RUN_BIT] && (live_count == COUNT_ZERO);
    run_rise = timer_control[RUN_BIT] && !run_prev;
  end

  assign pif.run = timer_control[RUN_BIT];
  assign pif.load = wr_presc;
  assign pif.value = wr_presc ? reg_wdata : prescaler_value;

  timer_prescaler u_prescaler (
    .clk(clk),
    .resetn(resetn),
    .pif(pif)
  );

  // Reload constant and programmed prescaler value.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      constant_high <= COUNTER_HIGH_RESET;
      constant_low <= COUNTER_LOW_RESET;
      prescaler_value <= PRESCALER_RESET;
    end else begin
      if (wr_high) begin
        constant_high <= reg_wdata;
      end
      if (wr_low) begin
        constant_low <= reg_wdata;
      end
      if (wr_presc) begin
        prescaler_value <= reg_wdata;
      end
    end
  end

  // Marks a constant written since it was last loaded into the counter.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      constant_pending <= 1'b0;
    end else if (wr_high || wr_low) begin
      constant_pending <= 1'b1;
    end else if (eoc || run_rise) begin
      constant_pending <= 1'b0;
    end
  end

  // Control register; a software set of run beats a single mode clear.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      timer_control <= CONTROL_RESET;
      run_prev <= 1'b0;
    end else begin
      run_prev <= timer_control[RUN_BIT];
      if (wr_ctrl) begin
        timer_control <= (reg_wdata & CONTROL_WRITABLE)
          | (CONTROL_RESET & ~CONTROL_WRITABLE);
        if (eoc && timer_control[MODE_BIT] && !reg_wdata[RUN_BIT]) begin
          timer_control[RUN_BIT] <= 1'b0;
        end
      end else if (eoc && timer_control[MODE_BIT]) begin
        timer_control[RUN_BIT] <= 1'b0;
      end
    end
  end

  // The live down counter.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      live_count <= {COUNTER_HIGH_RESET, COUNTER_LOW_RESET};
    end else if (run_rise && constant_pending) begin
      live_count <= {constant_high, constant_low};
    end else if (eoc) begin
      live_count <= {constant_high, constant_low};
    end else if (pif.tick && timer_control[RUN_BIT]) begin
      live_count <= live_count - 16'h0001;
    end
  end

  // Interrupt channel source selection.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_channel <= 1'b0;
      end_of_count <= 1'b0;
    end else begin
      end_of_count <= eoc;
      if (timer_control[IRQ_SEL_BIT]) begin
        irq_channel <= ext_irq_pin;
      end else begin
        irq_channel <= eoc;
      end
    end
  end

  // Registered read data.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && page_hit) begin
      case (reg_addr)
        ADDR_COUNTER_HIGH: reg_rdata <= live_count[15:8];
        ADDR_COUNTER_LOW: reg_rdata <= live_count[7:0];
        ADDR_PRESCALER: reg_rdata <= prescaler_value;
        ADDR_CONTROL: reg_rdata <= timer_control;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : standard_down_timer

/* File: core/std_timer_pkg.sv */
// Constants shared by the standard down timer design files.
package std_timer_pkg;
  localparam logic [7:0] REG_PAGE = 8'h0b;
  localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hf0;
  localparam logic [7:0] ADDR_COUNTER_LOW = 8'hf1;
  localparam logic [7:0] ADDR_PRESCALER = 8'hf2;
  localparam logic [7:0] ADDR_CONTROL = 8'hf3;
  localparam logic [7:0] COUNTER_HIGH_RESET = 8'hff;
  localparam logic [7:0] COUNTER_LOW_RESET = 8'hff;
  localparam logic [7:0] PRESCALER_RESET = 8'hff;
  localparam logic [7:0] CONTROL_RESET = 8'h14;
  localparam int RUN_BIT = 7;
  localparam int MODE_BIT = 6;
  localparam int IRQ_SEL_BIT = 2;
  localparam logic [7:0] CONTROL_WRITABLE = 8'hc4;
  localparam logic [1:0] CORE_DIV_LAST = 2'h3;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [7:0] PRESCALE_ZERO = 8'h00;
endpackage : std_timer_pkg

/* File: core/timer_prescaler.sv */
// Core clock divide by four followed by the programmable 8-bit prescaler.
`timescale 1ns/1ps
module timer_prescaler
  import std_timer_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  prescale_if.presc pif
);
  logic [1:0] core_div;
  logic [7:0] presc_count;

  // A free running divide by four of the core clock.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      core_div <= 2'h0;
    end else begin
      core_div <= core_div + 2'h1;
    end
  end

  // Divides the quarter rate by value plus one; a new value loads at once.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      presc_count <= PRESCALER_RESET;
      pif.tick <= 1'b0;
    end else begin
      pif.tick <= 1'b0;
      if (pif.load || !pif.run) begin
        presc_count <= pif.value;
      end else if (core_div == CORE_DIV_LAST) begin
        if (presc_count == PRESCALE_ZERO) begin
          presc_count <= pif.value;
          pif.tick <= 1'b1;
        end else begin
          presc_count <= presc_count - 8'h01;
        end
      end
    end
  end
endmodule : timer_prescaler

/* File: testbench/irq_peer.sv */
// Far-side model: external pin driver and channel request counter.
`timescale 1ns/1ps
module irq_peer (
  input wire logic clk,
  input wire logic pin_en,
  input wire logic irq_channel,
  output logic ext_irq_pin,
  output int pin_rises,
  output int irq_rises
);
  logic last;
  initial begin
    ext_irq_pin = 1'b0;
    pin_rises = 0;
    irq_rises = 0;
    last = 1'b0;
  end
  always @(negedge clk) begin
    ext_irq_pin <= pin_en && !ext_irq_pin;
    if (pin_en && !ext_irq_pin) pin_rises++;
  end
  always @(posedge clk) begin
    last <= irq_channel;
    if (irq_channel && !last) irq_rises++;
  end
endmodule : irq_peer

/* File: testbench/tb.sv */
// Self-checking testbench for the standard down timer.
`timescale 1ns/1ps
module tb;
  import std_timer_pkg::*;
  logic clk, resetn, reg_wr, reg_rd, pin_en, ext_irq_pin, irq_channel, end_of_count;
  logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata, d, hv;
  logic [7:0] rv [5] = '{8'hff, 8'hff, 8'hff, 8'h14, 8'h00};
  int error_cnt, compares, pr, ir, n;
  standard_down_timer i_standard_down_timer (.clk(clk), .resetn(resetn),
    .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin),
    .irq_channel(irq_channel), .end_of_count(end_of_count));
  irq_peer i_irq_peer (.clk(clk), .pin_en(pin_en), .irq_channel(irq_channel),
    .ext_irq_pin(ext_irq_pin), .pin_rises(pr), .irq_rises(ir));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task end_sim;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
  task wt(output int c);
    c = 1;
    @(negedge clk);
    while (end_of_count !== 1'b1 && c < 3000) begin
      @(negedge clk);
      c++;
    end
    if (c >= 3000) begin
      error_cnt++;
      end_sim();
    end
  endtask : wt
  initial begin
    {resetn, reg_wr, reg_rd, pin_en, reg_addr, reg_wdata} = '0;
    reg_page = REG_PAGE;
    error_cnt = 0;
    compares = 0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(8'hf0 + 8'(i));
      chk("reset", 16'(rv[i]), 16'(d));
    end
    reg_page = 8'h0a;
    rd(ADDR_CONTROL);
    chk("page", 16'h0000, 16'(d));
    reg_page = REG_PAGE;
    pin_en = 1'b1;
    repeat (20) @(negedge clk);
    pin_en = 1'b0;
    repeat (3) @(negedge clk);
    chk("pin", 16'(pr), 16'(ir));
    wr(ADDR_CONTROL, 8'h3b);
    rd(ADDR_CONTROL);
    chk("ctl", 16'h0010, 16'(d));
    wr(ADDR_COUNTER_HIGH, 8'h00);
    wr(ADDR_COUNTER_LOW, 8'h03);
    wr(ADDR_CONTROL, 8'h80);
    for (int p = 0; p < 3; p++) begin
      wr(ADDR_PRESCALER, 8'(p));
      rd(ADDR_PRESCALER);
      chk("presc", 16'(p), 16'(d));
      wt(n);
      wt(n);
      chk("period", 16'(16 * (p + 1)), 16'(n));
    end
    wr(ADDR_COUNTER_LOW, 8'h07);
    wt(n);
    wt(n);
    chk("reload", 16'd96, 16'(n));
    wr(ADDR_CONTROL, 8'hc0);
    wt(n);
    rd(ADDR_CONTROL);
    chk("single", 16'h0050, 16'(d));
    repeat (200) @(negedge clk);
    rd(ADDR_COUNTER_LOW);
    chk("held", 16'h0007, 16'(d));
    wr(ADDR_CONTROL, 8'h80);
    repeat (30) @(negedge clk);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNTER_LOW);
    hv = d;
    repeat (50) @(negedge clk);
    rd(ADDR_COUNTER_LOW);
    chk("stop", 16'(hv), 16'(d));
    wr(ADDR_CONTROL, 8'h80);
    rd(ADDR_COUNTER_LOW);
    chk("resume", 16'(hv), 16'(d));
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNTER_LOW, 8'h05);
    wr(ADDR_CONTROL, 8'h80);
    rd(ADDR_COUNTER_LOW);
    chk("newconst", 16'h0005, 16'(d));
    end_sim();
  end
endmodule : tb

/* File: testbench/timer_properties.sv */
// Port checker for the standard down timer.
`timescale 1ns/1ps
module timer_properties
  import std_timer_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic ext_irq_pin,
  input wire logic irq_channel,
  input wire logic end_of_count
);
  logic [7:0] presc;
  logic [7:0] ctl;
  logic hit;
  assign hit = reg_page == REG_PAGE;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      presc <= PRESCALER_RESET;
      ctl <= CONTROL_RESET;
    end else if (reg_wr && hit) begin
      if (reg_addr == ADDR_PRESCALER) presc <= reg_wdata;
      if (reg_addr == ADDR_CONTROL) ctl <= reg_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  eoc_gap_a: assert property (end_of_count |=> !end_of_count [*3])
    else $error("end of count too close");
  page_guard_a: assert property (reg_rd && !hit |=> reg_rdata == 8'h00)
    else $error("foreign page answered");
  addr_guard_a: assert property (reg_rd && (reg_addr < 8'hf0 || reg_addr > 8'hf3) |=>
    reg_rdata == 8'h00) else $error("unmapped address answered");
  ctrl_read_a: assert property (reg_rd && hit && reg_addr == ADDR_CONTROL |=>
    reg_rdata[6:0] == {ctl[6], 3'h2, ctl[2], 2'h0}) else $error("control read wrong");
  presc_read_a: assert property (reg_rd && hit && reg_addr == ADDR_PRESCALER |=>
    reg_rdata == presc) else $error("prescaler read wrong");
  irq_pin_a: assert property (ctl[2] && $past(ctl[2]) |->
    irq_channel == $past(ext_irq_pin)) else $error("pin not routed");
  irq_timer_a: assert property (!ctl[2] && !$past(ctl[2]) |->
    irq_channel == end_of_count) else $error("timer request not routed");
  cover property (end_of_count && !ctl[2]);
  cover property (irq_channel && ctl[2]);
  cover property (reg_rd && reg_addr == ADDR_CONTROL);
endmodule : timer_properties
bind standard_down_timer timer_properties i_timer_properties (.*);
